// ===== rtl/wppd_delay_mem.sv
// Circular sample store used as a variable tap delay line
module wppd_delay_mem #(
    parameter int W = 40,
    parameter int AW = 8
) (
    input wire logic CLOCK,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    if (AW < 8) begin : g_chk
        $error("Delay store needs at least 256 entries");
    end

    logic [W-1:0] mem [0:(1<<AW)-1];

    // No reset: contents are overwritten within one trip round the buffer
    always_ff @(posedge CLOCK) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ===== rtl/wppd_one_pole.sv
// Single-pole low-pass section, y += (x - y) * coef
module wppd_one_pole #(
    parameter int W = 24,
    parameter logic [15:0] COEF = 16'h0100
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic en,
    input wire logic signed [W-1:0] x,
    output logic signed [W-1:0] y
);
    localparam int AW = W + wppd_pkg::COEF_FRAC;

    if (W < 8 || COEF == 16'h0000) begin : g_chk
        $error("Filter width or coefficient unusable");
    end

    typedef struct packed {
        logic signed [AW-1:0] acc;
    } wppd_pole_state_t;

    wppd_pole_state_t s, next_s;
    logic signed [AW:0] diff;
    logic signed [AW+17:0] prod;

    // Fraction bits kept in the accumulator so small steps are not lost
    always_comb begin
        next_s = s;
        diff = {x[W-1], x, {wppd_pkg::COEF_FRAC{1'b0}}} - {s.acc[AW-1], s.acc};
        prod = diff * $signed({1'b0, COEF});
        if (en) begin
            next_s.acc = s.acc + AW'(prod >>> wppd_pkg::COEF_FRAC);
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign y = s.acc[AW-1 -: W];
endmodule

// ===== rtl/wppd_pkg.sv
// Shared constants and types for the waveform, phase and power signal path
package wppd_pkg;
    localparam int CLK_MHZ = 40;
    localparam int TRIM_STEP_NS = 1120;
    localparam int TICK_CYCLES = (TRIM_STEP_NS * CLK_MHZ) / 1000;
    localparam int TICKS_PER_SAMPLE = 32;
    localparam int ADC_W = 20;
    localparam int OUT_W = 24;
    localparam int WORD_W = 40;
    localparam int DELAY_AW = 8;
    localparam logic [7:0] NOMINAL_DELAY = 8'h62;
    localparam logic signed [7:0] TRIM_MIN = 8'sh9e;
    localparam logic signed [7:0] TRIM_MAX = 8'sh5c;
    localparam logic [7:0] TRIM_RESET = 8'h00;
    localparam int GAIN_SHIFT = 12;
    localparam int POWER_SHIFT = 18;
    localparam int COEF_FRAC = 16;
    localparam logic [15:0] SMOOTH_COEF = 16'h08f9;
    localparam logic [15:0] POWER_DC_COEF = 16'h0093;
    localparam logic [2:0] BYTES_WIDE = 3'h5;
    localparam logic [2:0] BYTES_NARROW = 3'h3;

    typedef enum logic [1:0] {
        WAVE_POWER = 2'b00,
        WAVE_COMBINED = 2'b01,
        WAVE_CURRENT = 2'b10,
        WAVE_VOLTAGE = 2'b11
    } wppd_wave_mode_t;
endpackage

// ===== rtl/wppd_top.sv
// Waveform sampling, phase trim and active power path of the metering core
// How it works
// - Mode 01 delivers one 40-bit combined word
// - Pack V[19:16], I[19:16], I[15:0], V[15:0]
// - Mode 11 delivers voltage samples, current scaling
// - Voltage waveform passes 156 Hz one-pole filter
// - Multiplier takes unfiltered voltage samples directly
// - Rate bits pick 28.4, 14.2, 7.1, 3.55 kSPS
// - New sample drives interrupt output low
// - Each trim step shifts voltage delay 1.1 us (44 clocks at 40 MHz)
// - Negative trim shortens delay, giving phase lead
// - Instantaneous power is current times voltage
// - Second low-pass filter extracts active power
// - Power gain 800h minimum, 7FFh maximum range
// - Channels delay-matched for zero phase error
// - Mode 10 routes current samples out
// - Mode 00 routes active power out
// - Gain is one plus signed value over 4096
module wppd_top (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [19:0] CURRENT_CHANNEL,
    input wire logic [19:0] VOLTAGE_CHANNEL,
    input wire logic [1:0] WAVE_MODE,
    input wire logic [1:0] SAMPLE_RATE_SELECT,
    input wire logic SAMPLE_READY_IRQ_ENABLE,
    input wire logic [11:0] POWER_GAIN_TRIM,
    input wire logic TRIM_WR,
    input wire logic [7:0] TRIM_WDATA,
    input wire logic BYTE_NEXT,
    input wire logic WAVE_ACK,
    output logic [7:0] PHASE_DELAY_TRIM,
    output logic [39:0] WAVE_WORD,
    output logic [7:0] WAVE_BYTE,
    output logic [2:0] WAVE_BYTES,
    output logic [23:0] ACTIVE_POWER,
    output logic IRQ_N
);
    localparam int AW = wppd_pkg::DELAY_AW;
    localparam int PW = wppd_pkg::ADC_W + 1 + wppd_pkg::ADC_W;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_CUR,
        ST_RD_VOL,
        ST_MUL,
        ST_FILT,
        ST_SETTLE,
        ST_LOAD
    } wppd_seq_t;

    typedef struct packed {
        logic [5:0] div;
        logic [4:0] tick_cnt;
        logic [AW-1:0] wp;
        wppd_seq_t st;
        logic [7:0] trim;
        logic [19:0] cur;
        logic [19:0] vol;
        logic [23:0] pinst;
        logic [2:0] rcnt;
        logic [39:0] word;
        logic [2:0] nbytes;
        logic [2:0] idx;
        logic [7:0] wbyte;
        logic irq_n;
        logic primed;
    } wppd_state_t;

    wppd_state_t s, next_s;

    logic tick;
    logic [AW-1:0] rd_addr;
    logic [39:0] rd_data;
    logic [7:0] vol_delay;
    logic signed [7:0] wr_trim;
    logic signed [20:0] cur_gain;
    logic signed [31:0] gain_prod;
    logic signed [PW-1:0] pprod;
    logic signed [23:0] smooth_y;
    logic signed [23:0] power_y;
    logic [2:0] rate_mask;
    logic [2:0] sel;
    logic irq_set;

    assign tick = (s.div == 6'(wppd_pkg::TICK_CYCLES - 1));

    // Voltage delay is nominal plus trim; current always sees the nominal
    assign vol_delay = wppd_pkg::NOMINAL_DELAY + s.trim;

    always_comb begin
        next_s = s;
        rd_addr = s.wp - 8'h01 - wppd_pkg::NOMINAL_DELAY;
        wr_trim = $signed(TRIM_WDATA);
        cur_gain = '0;
        gain_prod = '0;
        pprod = '0;
        rate_mask = (3'h1 << SAMPLE_RATE_SELECT) - 3'h1;
        sel = '0;
        irq_set = 1'b0;

        next_s.div = tick ? 6'h00 : s.div + 6'h01;

        // Out-of-range writes are clamped so the tap never wraps the buffer
        if (TRIM_WR) begin
            if (wr_trim < wppd_pkg::TRIM_MIN) begin
                next_s.trim = wppd_pkg::TRIM_MIN;
            end else if (wr_trim > wppd_pkg::TRIM_MAX) begin
                next_s.trim = wppd_pkg::TRIM_MAX;
            end else begin
                next_s.trim = TRIM_WDATA;
            end
        end

        if (tick) begin
            next_s.wp = s.wp + 8'h01;
            next_s.tick_cnt = s.tick_cnt + 5'h01;
            // Unwritten store entries would poison both filters for good
            if (s.wp == '1) begin
                next_s.primed = 1'b1;
            end
        end

        case (s.st)
            ST_IDLE: begin
                if (tick && s.tick_cnt == 5'(wppd_pkg::TICKS_PER_SAMPLE - 1)) begin
                    next_s.st = ST_RD_CUR;
                end
            end
            ST_RD_CUR: begin
                next_s.st = ST_RD_VOL;
            end
            ST_RD_VOL: begin
                // Current tap from the nominal address lands now
                rd_addr = s.wp - 8'h01 - vol_delay;
                next_s.cur = s.primed ? rd_data[39:20] : 20'h00000;
                next_s.st = ST_MUL;
            end
            ST_MUL: begin
                next_s.vol = s.primed ? rd_data[19:0] : 20'h00000;
                next_s.st = ST_FILT;
            end
            ST_FILT: begin
                // Gain applies as I * (1 + g / 4096) ahead of the multiplier
                gain_prod = $signed(s.cur) * $signed(POWER_GAIN_TRIM);
                cur_gain = $signed({s.cur[19], s.cur})
                    + 21'(gain_prod >>> wppd_pkg::GAIN_SHIFT);
                pprod = cur_gain * $signed(s.vol);
                next_s.pinst = 24'(pprod >>> wppd_pkg::POWER_SHIFT);
                next_s.st = ST_SETTLE;
            end
            ST_SETTLE: begin
                next_s.st = ST_LOAD;
            end
            ST_LOAD: begin
                next_s.st = ST_IDLE;
                next_s.rcnt = s.rcnt + 3'h1;
                if ((s.rcnt & rate_mask) == 3'h0) begin
                    next_s.nbytes = wppd_pkg::BYTES_NARROW;
                    case (WAVE_MODE)
                        wppd_pkg::WAVE_POWER: begin
                            next_s.word = 40'(power_y);
                        end
                        wppd_pkg::WAVE_COMBINED: begin
                            next_s.word = {s.vol[19:16], s.cur[19:16],
                                s.cur[15:0], s.vol[15:0]};
                            next_s.nbytes = wppd_pkg::BYTES_WIDE;
                        end
                        wppd_pkg::WAVE_CURRENT: begin
                            next_s.word = 40'($signed(s.cur));
                        end
                        default: begin
                            next_s.word = 40'(smooth_y);
                        end
                    endcase
                    next_s.idx = 3'h0;
                    sel = next_s.nbytes - 3'h1;
                    next_s.wbyte = 8'(next_s.word >> {sel, 3'b000});
                    if (SAMPLE_READY_IRQ_ENABLE) begin
                        next_s.irq_n = 1'b0;
                        irq_set = 1'b1;
                    end
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase

        // A new sample in the same cycle as an acknowledge keeps the request
        if (WAVE_ACK && !irq_set) begin
            next_s.irq_n = 1'b1;
        end
        if (BYTE_NEXT && s.st != ST_LOAD && s.idx < s.nbytes - 3'h1) begin
            next_s.idx = s.idx + 3'h1;
            sel = s.nbytes - 3'h2 - s.idx;
            next_s.wbyte = 8'(s.word >> {sel, 3'b000});
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            s <= '{div: '0, tick_cnt: '0, wp: '0, st: ST_IDLE,
                trim: wppd_pkg::TRIM_RESET, cur: '0, vol: '0, pinst: '0,
                rcnt: '0, word: '0, nbytes: wppd_pkg::BYTES_NARROW, idx: '0,
                wbyte: '0, irq_n: 1'b1, primed: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // Both channels share one store so their fixed delays match exactly
    wppd_delay_mem #(
        .W(40),
        .AW(AW)
    ) u_delay (
        .CLOCK(CLOCK),
        .wr_en(tick),
        .wr_addr(s.wp),
        .wr_data({CURRENT_CHANNEL, VOLTAGE_CHANNEL}),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    wppd_one_pole #(
        .W(24),
        .COEF(wppd_pkg::SMOOTH_COEF)
    ) u_smooth (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .en(s.st == ST_FILT),
        .x(24'($signed(s.vol))),
        .y(smooth_y)
    );

    wppd_one_pole #(
        .W(24),
        .COEF(wppd_pkg::POWER_DC_COEF)
    ) u_power_dc (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .en(s.st == ST_SETTLE),
        .x(s.pinst),
        .y(power_y)
    );

    assign PHASE_DELAY_TRIM = s.trim;
    assign WAVE_WORD = s.word;
    assign WAVE_BYTE = s.wbyte;
    assign WAVE_BYTES = s.nbytes;
    assign ACTIVE_POWER = power_y;
    assign IRQ_N = s.irq_n;
endmodule

// ===== tb/wppd_host_model.sv
// Host model that drains each waveform word byte by byte, then acknowledges
module wppd_host_model (
    input wire logic CLOCK,
    input wire logic rst_n,
    input wire logic irq_n,
    input wire logic [7:0] wave_byte,
    input wire logic [2:0] wave_bytes,
    input wire logic [3:0] slow,
    output logic byte_next,
    output logic wave_ack,
    output logic [39:0] got,
    output int count
);
    timeunit 1ns;
    timeprecision 100ps;
    logic busy;
    logic [2:0] idx;
    logic [3:0] hold;
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            {busy, byte_next, wave_ack, idx, hold} <= '0;
            got <= '0;
            count <= 0;
        end else begin
            byte_next <= 1'b0;
            wave_ack <= 1'b0;
            // At least one idle edge for slow up to 14 (15 wraps hold to 0) so the advanced byte has landed
            if (hold != 4'h0) begin
                hold <= hold - 4'h1;
            end else if (!busy && !irq_n && !wave_ack) begin
                busy <= 1'b1;
                idx <= 3'h0;
                got <= '0;
                hold <= slow;
            end else if (busy) begin
                got <= {got[31:0], wave_byte};
                idx <= idx + 3'h1;
                hold <= slow + 4'h1;
                if (idx + 3'h1 == wave_bytes) begin
                    busy <= 1'b0;
                    wave_ack <= 1'b1;
                    count <= count + 1;
                end else begin
                    byte_next <= 1'b1;
                end
            end
        end
    end
endmodule

// ===== tb/wppd_top_assertions.sv
// Port-level property checker for the waveform, phase and power path
module wppd_checker (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [1:0] WAVE_MODE,
    input wire logic SAMPLE_READY_IRQ_ENABLE,
    input wire logic TRIM_WR,
    input wire logic [7:0] TRIM_WDATA,
    input wire logic WAVE_ACK,
    input wire logic [7:0] PHASE_DELAY_TRIM,
    input wire logic [39:0] WAVE_WORD,
    input wire logic [7:0] WAVE_BYTE,
    input wire logic [2:0] WAVE_BYTES,
    input wire logic [23:0] ACTIVE_POWER,
    input wire logic IRQ_N
);
    timeunit 1ns;
    timeprecision 100ps;
    int gap;
    logic seen;
    logic irq_q;
    function automatic logic [7:0] clamp(input logic [7:0] d);
        if ($signed(d) < $signed(8'h9e)) return 8'h9e;
        if ($signed(d) > $signed(8'h5c)) return 8'h5c;
        return d;
    endfunction
    // Loads sit on a fixed sample grid, so falls are whole base periods apart
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            gap <= 0;
            seen <= 1'b0;
            irq_q <= 1'b1;
        end else begin
            irq_q <= IRQ_N;
            if (irq_q && !IRQ_N) begin
                gap <= 1;
                seen <= 1'b1;
            end else begin
                gap <= gap + 1;
            end
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    sequence s_load;
        $fell(IRQ_N);
    endsequence
    sequence s_ack;
        WAVE_ACK && !IRQ_N;
    endsequence
    property p_trim;
        TRIM_WR |=> PHASE_DELAY_TRIM == clamp($past(TRIM_WDATA));
    endproperty
    a_trim: assert property (p_trim) else $error("trim readback wrong");
    property p_gate;
        !SAMPLE_READY_IRQ_ENABLE && IRQ_N |=> IRQ_N;
    endproperty
    a_gate: assert property (p_gate) else $error("irq while disabled");
    property p_hold;
        !IRQ_N && !WAVE_ACK |=> !IRQ_N;
    endproperty
    a_hold: assert property (p_hold) else $error("irq dropped early");
    property p_ack;
        s_ack |=> IRQ_N;
    endproperty
    a_ack: assert property (p_ack) else $error("irq not released");
    property p_first;
        s_load |-> WAVE_BYTE == (WAVE_BYTES == 3'h5 ? WAVE_WORD[39:32] : WAVE_WORD[23:16]);
    endproperty
    a_first: assert property (p_first) else $error("first byte wrong");
    property p_count;
        s_load |-> WAVE_BYTES == (WAVE_MODE == 2'b01 ? 3'h5 : 3'h3);
    endproperty
    a_count: assert property (p_count) else $error("byte count wrong");
    property p_power;
        s_load ##0 WAVE_MODE == 2'b00 |-> WAVE_WORD[23:0] == ACTIVE_POWER;
    endproperty
    a_power: assert property (p_power) else $error("power not routed");
    property p_rate;
        s_load |-> !seen || gap % 1408 == 0;
    endproperty
    a_rate: assert property (p_rate) else $error("sample spacing wrong");
endmodule
bind wppd_top wppd_checker wppd_checker_i (.CLOCK(CLOCK), .RST_N(RST_N),
    .WAVE_MODE(WAVE_MODE), .SAMPLE_READY_IRQ_ENABLE(SAMPLE_READY_IRQ_ENABLE),
    .TRIM_WR(TRIM_WR), .TRIM_WDATA(TRIM_WDATA), .WAVE_ACK(WAVE_ACK),
    .PHASE_DELAY_TRIM(PHASE_DELAY_TRIM), .WAVE_WORD(WAVE_WORD), .WAVE_BYTE(WAVE_BYTE),
    .WAVE_BYTES(WAVE_BYTES), .ACTIVE_POWER(ACTIVE_POWER), .IRQ_N(IRQ_N));

// ===== tb/wppd_top_tb.sv
// Self-checking bench for the waveform, phase and power path
module wppd_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic [19:0] cur = 20'hd7ae1;
    logic [19:0] volt = 20'h2851f;
    logic [1:0] mode = 2'b01;
    logic [1:0] rate = 2'b00;
    logic irq_en = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [3:0] slow = 4'h3;
    logic [11:0] gain = 12'h000;
    int p0, d_hi;
    logic byte_next, wave_ack, irq_n;
    logic [7:0] trim, wbyte;
    logic [39:0] word, got;
    logic [2:0] nbytes;
    logic [23:0] power;
    int words, t0, n_errors = 0, check_count = 0, cyc = 0;
    always #12.5 CLOCK = ~CLOCK;
    wppd_top wppd_top_i (.CLOCK(CLOCK), .RST_N(RST_N), .CURRENT_CHANNEL(cur),
        .VOLTAGE_CHANNEL(volt), .WAVE_MODE(mode), .SAMPLE_RATE_SELECT(rate),
        .SAMPLE_READY_IRQ_ENABLE(irq_en), .POWER_GAIN_TRIM(gain), .TRIM_WR(wr),
        .TRIM_WDATA(wdata), .BYTE_NEXT(byte_next), .WAVE_ACK(wave_ack),
        .PHASE_DELAY_TRIM(trim), .WAVE_WORD(word), .WAVE_BYTE(wbyte),
        .WAVE_BYTES(nbytes), .ACTIVE_POWER(power), .IRQ_N(irq_n));
    wppd_host_model wppd_host_model_i (.CLOCK(CLOCK), .rst_n(RST_N), .irq_n(irq_n),
        .wave_byte(wbyte), .wave_bytes(nbytes), .slow(slow), .byte_next(byte_next),
        .wave_ack(wave_ack), .got(got), .count(words));
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic put_trim(input logic [7:0] d, input logic [7:0] exp);
        @(posedge CLOCK);
        wr <= 1'b1;
        wdata <= d;
        @(posedge CLOCK);
        wr <= 1'b0;
        @(negedge CLOCK);
        check({32'h0, trim}, {32'h0, exp});
    endtask
    task automatic wait_words(input int n);
        int t;
        t = words + n;
        while (words < t) @(posedge CLOCK);
    endtask
    // Whole run needs about 88k cycles at worst
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (cyc == 97000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (16) @(posedge CLOCK);
        RST_N <= 1'b1;
        @(negedge CLOCK);
        check({32'h0, trim}, 40'h0);
        check({37'h0, nbytes}, 40'h3);
        check({39'h0, irq_n}, 40'h1);
        put_trim(8'hfc, 8'hfc);
        put_trim(8'h80, 8'h9e);
        put_trim(8'h7f, 8'h5c);
        put_trim(8'h9e, 8'h9e);
        put_trim(8'h5c, 8'h5c);
        @(posedge CLOCK);
        irq_en <= 1'b1;
        wait_words(10);
        check(got, {volt[19:16], cur[19:16], cur[15:0], volt[15:0]});
        check(word, {volt[19:16], cur[19:16], cur[15:0], volt[15:0]});
        // Trim +92 puts the voltage tap 190 ticks back, current 98: new I, old V
        cur <= 20'hc8421;
        volt <= 20'h31357;
        wait_words(4);
        check(word, 40'h2c8421851f);
        mode <= 2'b10;
        slow <= 4'h0;
        wait_words(3);
        check(word, {{20{cur[19]}}, cur});
        check(got[23:0], {{4{cur[19]}}, cur});
        mode <= 2'b11;
        wait_words(8);
        check({39'h0, $signed(word) > 0 && $signed(word) < $signed({20'h0, volt})}, 40'h1);
        check({39'h0, power[23]}, 40'h1);
        mode <= 2'b00;
        wait_words(2);
        check({39'h0, word[23]}, 40'h1);
        // Largest gain must pull the negative power down faster than the smallest
        gain <= 12'h7ff;
        wait_words(1);
        p0 = $signed(word[23:0]);
        wait_words(1);
        d_hi = $signed(word[23:0]) - p0;
        gain <= 12'h800;
        wait_words(1);
        p0 = $signed(word[23:0]);
        wait_words(1);
        check({39'h0, $signed(word[23:0]) - p0 > d_hi}, 40'h1);
        for (int s = 0; s < 4; s++) begin
            @(posedge CLOCK);
            rate <= s[1:0];
            @(negedge irq_n);
            @(negedge CLOCK);
            t0 = cyc;
            @(negedge irq_n);
            @(negedge CLOCK);
            check(40'(cyc - t0), 40'(1408 << s));
        end
        @(posedge CLOCK);
        irq_en <= 1'b0;
        rate <= 2'b00;
        repeat (1500) @(posedge CLOCK);
        check({39'h0, irq_n}, 40'h1);
        end_sim();
    end
endmodule
